// *** cpeg_core.sv ***
// Electronic gear, command smoothing and deviation counter of the pulse-train position loop
// Requirements behind this block
// R1 - Scale command pulses by numerator over denominator
// R2 - Steady state: scaled rate matches feedback rate
// R3 - Count encoder quadrature edges times four
// R4 - Software keeps ratio between 1/50 and 20
// R5 - Panel entry of ratio capped at 9999
// R6 - Open-collector command pulses stay under 200kpps; the controller model sends one every six clocks
// R7 - Droop equals command rate over loop gain
// R8 - Controller waits three over gain to settle
// R9 - Ramp command rate over 0 to 50s
// R10 - Use smoothing for large ratio, low speed
// R11 - Ratio and ramp writable only with option fitted
// R12 - Clear input falling edge clears deviation counter
// R13 - In-position while droop below programmed width
// R14 - Carry scaling remainder between pulses
// R15 - Zero denominator rejected, previous ratio kept
`timescale 1ns/1ps
module cpeg_core #(
   parameter int unsigned RAMP_STEP_CYC = cpeg_pkg::RAMP_STEP_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cmd_fwd_pin,
   input wire logic cmd_rev_pin,
   input wire logic enc_a_pin,
   input wire logic enc_b_pin,
   input wire logic deviation_clear_input,
   input wire logic option_fitted_pin,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [31:0] speed_command,
   output logic in_position_output,
   output logic error_excess,
   output logic irq
);
   typedef struct packed {
      logic [5:0] sy1;
      logic [5:0] sy2;
      logic [5:0] sy3;
      logic [5:0] stab;
      logic [14:0] num;
      logic [14:0] den;
      logic [15:0] ramp;
      logic [15:0] gain;
      logic [15:0] inpos_w;
      logic [27:0] exc_lim;
      logic signed [39:0] acc;
      logic signed [27:0] dev;
      logic g_up;
      logic g_dn;
      logic [3:0] status;
      logic [3:0] mask;
      logic [31:0] rdata;
      logic [31:0] speed;
      logic in_pos;
      logic excess;
      logic irq;
   } cpeg_core_s;

   cpeg_core_s q;
   cpeg_core_s n;

   logic [5:0] pins;
   logic [5:0] agree;
   logic [5:0] stab_n;
   logic fwd_rise;
   logic rev_rise;
   logic clr_fall;
   logic a0;
   logic b0;
   logic a1;
   logic b1;
   logic fb_step;
   logic fb_up;
   logic fb_dn;
   logic cmd_up;
   logic cmd_dn;
   logic fitted;
   logic r_up;
   logic r_dn;
   logic den_rej;
   logic inpos_now;
   logic excess_now;
   logic [3:0] ev;
   logic [3:0] w1c;
   logic signed [39:0] num_s;
   logic signed [39:0] den_s;
   logic signed [39:0] add;
   logic signed [44:0] prod;
   logic [31:0] speed_now;
   logic [31:0] rd_val;

   // Limit a written value to a setting's top
   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lim);
      clamp = (v > lim) ? lim : v;
   endfunction : clamp

   // Saturate the speed product into 32 signed bits rather than wrap
   function automatic logic [31:0] sat32(input logic signed [44:0] v);
      if (v > 45'sh0007fffffff) begin
         sat32 = 32'h7fffffff;
      end else if (v < -45'sh00080000000) begin
         sat32 = 32'h80000000;
      end else begin
         sat32 = v[31:0];
      end
   endfunction : sat32

   // Pins enter a three-stage synchroniser
   assign pins = {option_fitted_pin, deviation_clear_input, enc_b_pin, enc_a_pin, cmd_rev_pin, cmd_fwd_pin};

   // A pin level moves only once stages two and three agree, which drops one-cycle glitches
   assign agree = ~(q.sy2 ^ q.sy3);
   assign stab_n = (agree & q.sy2) | (~agree & q.stab);

   // Edges of the filtered levels
   assign fwd_rise = stab_n[cpeg_pkg::PIN_FWD] & ~q.stab[cpeg_pkg::PIN_FWD];
   assign rev_rise = stab_n[cpeg_pkg::PIN_REV] & ~q.stab[cpeg_pkg::PIN_REV];
   assign clr_fall = q.stab[cpeg_pkg::PIN_CLR] & ~stab_n[cpeg_pkg::PIN_CLR]; // R12
   assign fitted = q.stab[cpeg_pkg::PIN_FIT];
   assign cmd_up = fwd_rise & ~rev_rise;
   assign cmd_dn = rev_rise & ~fwd_rise;

   // Every quadrature edge counts once; A leading B is forward
   assign a0 = q.stab[cpeg_pkg::PIN_ENC_A];
   assign b0 = q.stab[cpeg_pkg::PIN_ENC_B];
   assign a1 = stab_n[cpeg_pkg::PIN_ENC_A];
   assign b1 = stab_n[cpeg_pkg::PIN_ENC_B];
   assign fb_step = (a0 ^ a1) ^ (b0 ^ b1); // R3
   assign fb_up = fb_step & ~(a0 ^ b1);
   assign fb_dn = fb_step & (a0 ^ b1);

   // Gear operands at accumulator width
   assign num_s = $signed({25'h0, q.num});
   assign den_s = $signed({25'h0, q.den});
   assign add = cmd_up ? num_s : (cmd_dn ? -num_s : 40'sh0);

   // Droop times gain is the speed command handed to the speed loop
   assign prod = $signed(q.dev) * $signed({1'b0, q.gain}); // R7
   assign speed_now = sat32(prod); // R2

   // Position window and excess checks on the droop
   assign inpos_now = cpeg_pkg::mag(q.dev) < {12'h0, q.inpos_w}; // R13
   assign excess_now = cpeg_pkg::mag(q.dev) > q.exc_lim;

   // A zero denominator write with the option fitted is refused and flagged
   assign den_rej = reg_wr && fitted && reg_wdata == 32'h0 &&
                    (reg_addr == cpeg_pkg::OFS_DEN || reg_addr == cpeg_pkg::OFS_DEN_PANEL); // R15

   // Events that set sticky status
   assign ev[cpeg_pkg::ST_INPOS] = inpos_now & ~q.in_pos;
   assign ev[cpeg_pkg::ST_EXCESS] = excess_now & ~q.excess;
   assign ev[cpeg_pkg::ST_CLEAR] = clr_fall;
   assign ev[cpeg_pkg::ST_REJECT] = den_rej;
   assign w1c = (reg_wr && reg_addr == cpeg_pkg::OFS_STATUS) ? reg_wdata[3:0] : 4'h0;

   // Smoothing stage between the gear and the deviation counter
   cpeg_ramp #(
      .STEP_CYC(RAMP_STEP_CYC)
   ) u_ramp (
      .clk(clk),
      .rst_b(rst_b),
      .tau_ms(q.ramp),
      .in_up(q.g_up),
      .in_dn(q.g_dn),
      .out_up(r_up),
      .out_dn(r_dn)
   );

   // Read mux
   always_comb begin
      case (reg_addr)
         cpeg_pkg::OFS_NUM: rd_val = {17'h0, q.num};
         cpeg_pkg::OFS_DEN: rd_val = {17'h0, q.den};
         cpeg_pkg::OFS_RAMP: rd_val = {16'h0, q.ramp};
         cpeg_pkg::OFS_GAIN: rd_val = {16'h0, q.gain};
         cpeg_pkg::OFS_INPOS: rd_val = {16'h0, q.inpos_w};
         cpeg_pkg::OFS_EXCESS: rd_val = {4'h0, q.exc_lim};
         cpeg_pkg::OFS_STATUS: rd_val = {28'h0, q.status};
         cpeg_pkg::OFS_MASK: rd_val = {28'h0, q.mask};
         cpeg_pkg::OFS_DEV: rd_val = {{4{q.dev[27]}}, q.dev};
         cpeg_pkg::OFS_SPEED: rd_val = q.speed;
         default: rd_val = 32'h0;
      endcase
   end

   // Next-state logic of the whole block
   always_comb begin
      n = q;
      n.sy1 = pins;
      n.sy2 = q.sy1;
      n.sy3 = q.sy2;
      n.stab = stab_n;

      // Whole pulses leave the accumulator, the fraction stays for the next pulse
      n.g_up = q.acc >= den_s; // R1
      n.g_dn = q.acc <= -den_s;
      n.acc = q.acc + add - (n.g_up ? den_s : 40'sh0) + (n.g_dn ? den_s : 40'sh0); // R14

      // Deviation counter: smoothed command in, four-times feedback out
      n.dev = q.dev + (r_up ? 28'sh1 : 28'sh0) - (r_dn ? 28'sh1 : 28'sh0)
              - (fb_up ? 28'sh1 : 28'sh0) + (fb_dn ? 28'sh1 : 28'sh0); // R7
      if (clr_fall) begin
         n.dev = 28'sh0; // R12
      end

      n.speed = speed_now;
      n.in_pos = inpos_now; // R13
      n.excess = excess_now;

      // Register writes; ratio and ramp settings need the option present
      if (reg_wr) begin
         case (reg_addr)
            cpeg_pkg::OFS_NUM: begin
               if (fitted) begin
                  n.num = 15'(clamp(reg_wdata, cpeg_pkg::SET_MAX)); // R11
               end
            end
            cpeg_pkg::OFS_DEN: begin
               if (fitted && !den_rej) begin
                  n.den = 15'(clamp(reg_wdata, cpeg_pkg::SET_MAX)); // R15
               end
            end
            cpeg_pkg::OFS_NUM_PANEL: begin
               if (fitted) begin
                  n.num = 15'(clamp(reg_wdata, cpeg_pkg::PANEL_MAX)); // R5
               end
            end
            cpeg_pkg::OFS_DEN_PANEL: begin
               if (fitted && !den_rej) begin
                  n.den = 15'(clamp(reg_wdata, cpeg_pkg::PANEL_MAX)); // R5
               end
            end
            cpeg_pkg::OFS_RAMP: begin
               if (fitted) begin
                  n.ramp = 16'(clamp(reg_wdata, cpeg_pkg::RAMP_MAX)); // R9
               end
            end
            cpeg_pkg::OFS_GAIN: n.gain = reg_wdata[15:0];
            cpeg_pkg::OFS_INPOS: n.inpos_w = reg_wdata[15:0];
            cpeg_pkg::OFS_EXCESS: n.exc_lim = reg_wdata[27:0];
            cpeg_pkg::OFS_MASK: n.mask = reg_wdata[3:0];
            default: ;
         endcase
      end

      // Sticky status: a new event beats a clear in the same cycle
      n.status = (q.status & ~w1c) | ev;
      n.irq = |(n.status & n.mask);

      // Read data stand only in the cycle after the strobe
      n.rdata = reg_rd ? rd_val : 32'h0;
   end

   // State register; every field takes a constant at reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.num <= cpeg_pkg::RST_NUM;
         q.den <= cpeg_pkg::RST_DEN;
         q.ramp <= cpeg_pkg::RST_RAMP;
         q.gain <= cpeg_pkg::RST_GAIN;
         q.inpos_w <= cpeg_pkg::RST_INPOS;
         q.exc_lim <= cpeg_pkg::RST_EXCESS;
         q.mask <= cpeg_pkg::RST_MASK;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = q.rdata;
   assign speed_command = q.speed;
   assign in_position_output = q.in_pos;
   assign error_excess = q.excess;
   assign irq = q.irq;

   default clocking cpeg_core_cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_clear_dev: // R12
   assert property (clr_fall |=> q.dev == 28'sh0)
      else $error("Deviation not cleared after clear edge");
   chk_den_nonzero: // R15
   assert property (q.den != 15'h0000)
      else $error("Denominator reached zero");
   chk_panel_cap: // R5
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_NUM_PANEL && fitted && reg_wdata > cpeg_pkg::PANEL_MAX)
      |=> q.num == 15'(cpeg_pkg::PANEL_MAX))
      else $error("Panel numerator not capped");
   chk_option_gate: // R11
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_NUM && !fitted) |=> $stable(q.num))
      else $error("Numerator written without option");
   chk_fb_step: // R3
   assert property ((fb_up && !fb_dn && !r_up && !r_dn && !clr_fall) |=> q.dev == $past(q.dev) - 28'sh1)
      else $error("Feedback edge not counted");
   chk_gear_emit: // R1
   assert property (q.g_up |-> $past(q.acc) >= $past(den_s))
      else $error("Scaled pulse without whole count");
   chk_gear_remainder: // R14
   assert property ((!cmd_up && !cmd_dn && q.acc >= 40'sh0 && q.acc < den_s) |=> q.acc == $past(q.acc))
      else $error("Scaling remainder lost");
   chk_inpos_window: // R13
   assert property (1'b1 |=> in_position_output == $past(inpos_now))
      else $error("In-position output disagrees with droop");
   chk_speed_droop: // R7 R2
   assert property (1'b1 |=> speed_command == $past(speed_now))
      else $error("Speed command not droop times gain");
   chk_status_set_wins: // R13
   assert property ((ev[cpeg_pkg::ST_INPOS] && w1c[cpeg_pkg::ST_INPOS]) |=> q.status[cpeg_pkg::ST_INPOS])
      else $error("Status event lost to clear");
   chk_read_slot:
   assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("Read data outside its cycle");

   // Write gates, clamps and flags of the register side, and the excess and interrupt output levels
   chk_den_option: // R11
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_DEN && !fitted) |=> $stable(q.den))
      else $error("Denominator written without option");
   chk_ramp_option: // R11
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_RAMP && !fitted) |=> $stable(q.ramp))
      else $error("Time constant written without option");
   chk_num_clamp: // R1
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_NUM && fitted && reg_wdata > cpeg_pkg::SET_MAX)
      |=> q.num == 15'(cpeg_pkg::SET_MAX))
      else $error("Numerator not held at its top");
   chk_den_panel_cap: // R5
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_DEN_PANEL && fitted && reg_wdata > cpeg_pkg::PANEL_MAX)
      |=> q.den == 15'(cpeg_pkg::PANEL_MAX))
      else $error("Panel denominator not capped");
   chk_ramp_clamp: // R9
   assert property ((reg_wr && reg_addr == cpeg_pkg::OFS_RAMP && fitted && reg_wdata > cpeg_pkg::RAMP_MAX)
      |=> q.ramp == 16'(cpeg_pkg::RAMP_MAX))
      else $error("Time constant not held at its top");
   chk_reject_flag: // R15
   assert property (den_rej |=> q.status[cpeg_pkg::ST_REJECT])
      else $error("Zero denominator not flagged");
   chk_clear_flag: // R12
   assert property (clr_fall |=> q.status[cpeg_pkg::ST_CLEAR])
      else $error("Clear edge not flagged");
   chk_excess_level:
   assert property ((cpeg_pkg::mag(q.dev) > q.exc_lim) |=> error_excess)
      else $error("Excess output missed a large droop");
   chk_irq_level:
   assert property (irq == |(q.status & q.mask))
      else $error("Interrupt disagrees with status and mask");
endmodule : cpeg_core

// *** cpeg_pkg.sv ***
// Shared offsets, reset values, timing and helpers of the command pulse electronic gear
package cpeg_pkg;
   // Register word offsets on the plain register port
   localparam logic [3:0] OFS_NUM = 4'h0;
   localparam logic [3:0] OFS_DEN = 4'h1;
   localparam logic [3:0] OFS_RAMP = 4'h2;
   localparam logic [3:0] OFS_GAIN = 4'h3;
   localparam logic [3:0] OFS_INPOS = 4'h4;
   localparam logic [3:0] OFS_EXCESS = 4'h5;
   localparam logic [3:0] OFS_NUM_PANEL = 4'h6;
   localparam logic [3:0] OFS_DEN_PANEL = 4'h7;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [3:0] OFS_MASK = 4'h9;
   localparam logic [3:0] OFS_DEV = 4'ha;
   localparam logic [3:0] OFS_SPEED = 4'hb;

   // Setting limits
   localparam logic [31:0] SET_MAX = 32'h00007fff;
   localparam logic [31:0] PANEL_MAX = 32'h0000270f;
   localparam logic [31:0] RAMP_MAX = 32'h0000c350;

   // Values after reset
   localparam logic [14:0] RST_NUM = 15'h0001;
   localparam logic [14:0] RST_DEN = 15'h0001;
   localparam logic [15:0] RST_RAMP = 16'h0000;
   localparam logic [15:0] RST_GAIN = 16'h0019;
   localparam logic [15:0] RST_INPOS = 16'h0064;
   localparam logic [27:0] RST_EXCESS = 28'h0030000;
   localparam logic [3:0] RST_MASK = 4'h0;

   // Positions in the pin synchroniser vector
   localparam int PIN_FWD = 0;
   localparam int PIN_REV = 1;
   localparam int PIN_ENC_A = 2;
   localparam int PIN_ENC_B = 3;
   localparam int PIN_CLR = 4;
   localparam int PIN_FIT = 5;

   // Status and mask bit positions
   localparam int ST_INPOS = 0;
   localparam int ST_EXCESS = 1;
   localparam int ST_CLEAR = 2;
   localparam int ST_REJECT = 3;

   // Ramp time base: one step per millisecond at the 4 ns clock
   localparam int CLK_NS = 4;
   localparam int RAMP_STEP_NS = 1000000;
   localparam int RAMP_STEP_CYC = RAMP_STEP_NS / CLK_NS;

   // Magnitude of a signed deviation-width value
   function automatic logic [27:0] mag(input logic signed [27:0] v);
      mag = v[27] ? 28'(-v) : 28'(v);
   endfunction : mag
endpackage : cpeg_pkg

// *** cpeg_ramp.sv ***
// First-order smoothing of the scaled command pulse stream
`timescale 1ns/1ps
module cpeg_ramp #(
   parameter int unsigned STEP_CYC = cpeg_pkg::RAMP_STEP_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] tau_ms,
   input wire logic in_up,
   input wire logic in_dn,
   output logic out_up,
   output logic out_dn
);
   typedef struct packed {
      logic signed [27:0] backlog;
      logic [43:0] credit;
      logic [31:0] tick;
      logic up;
      logic dn;
   } cpeg_ramp_s;

   cpeg_ramp_s q;
   cpeg_ramp_s n;
   logic [43:0] credit_v;
   logic rel;
   logic pass;

   // Each step adds the backlog to a credit; one pulse leaves per tau of credit,
   // so the release rate is backlog / tau, a first-order lag
   always_comb begin
      n = q;
      credit_v = q.credit;
      rel = 1'b0;
      pass = (tau_ms == 16'h0000) && (q.backlog == 28'sh0);
      n.up = 1'b0;
      n.dn = 1'b0;
      if (q.tick >= 32'(STEP_CYC - 1)) begin
         n.tick = 32'h0;
         credit_v = q.credit + {16'h0, cpeg_pkg::mag(q.backlog)};
      end else begin
         n.tick = q.tick + 32'h1;
      end
      // An empty backlog must not bank credit, or the next move would jump
      if (q.backlog == 28'sh0) begin
         credit_v = 44'h0;
      end
      if (pass) begin
         n.up = in_up & ~in_dn; // R9
         n.dn = in_dn & ~in_up;
      end else begin
         // A zero time constant with a leftover backlog drains it at clock rate
         rel = (q.backlog != 28'sh0) && (tau_ms == 16'h0000 || credit_v >= {28'h0, tau_ms}); // R9
         if (rel && tau_ms != 16'h0000) begin
            credit_v = credit_v - {28'h0, tau_ms};
         end
         n.up = rel & ~q.backlog[27];
         n.dn = rel & q.backlog[27];
         n.backlog = q.backlog + (in_up ? 28'sh1 : 28'sh0) - (in_dn ? 28'sh1 : 28'sh0)
                     - (n.up ? 28'sh1 : 28'sh0) + (n.dn ? 28'sh1 : 28'sh0);
      end
      n.credit = credit_v;
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign out_up = q.up;
   assign out_dn = q.dn;

   default clocking cpeg_ramp_cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_ramp_bypass: // R9
   assert property ((tau_ms == 16'h0000 && q.backlog == 28'sh0 && in_up && !in_dn) |=> out_up)
      else $error("Zero time constant did not pass pulse");
   chk_ramp_idle: // R9
   assert property ((q.backlog == 28'sh0 && !in_up && !in_dn) |=> (!out_up && !out_dn))
      else $error("Pulse released from empty backlog");
endmodule : cpeg_ramp

// *** cpeg_ctrl_model.sv ***
// Behavioural model of the positioning controller that issues command pulse trains
`timescale 1ns/1ps
module cpeg_ctrl_model #(
   parameter int SETTLE = 30
) (
   input wire logic clk,
   output logic cmd_fwd,
   output logic cmd_rev
);
   // Both lines idle low from time zero so no stray edge follows reset
   initial begin
      cmd_fwd = 1'b0;
      cmd_rev = 1'b0;
   end

   // High and low three clocks each: slow enough for the pin filter, far faster than a real open-collector rate limit
   task automatic send(input int k, input logic rev);
      repeat (k) begin
         @(posedge clk);
         if (rev) begin
            cmd_rev <= 1'b1;
         end else begin
            cmd_fwd <= 1'b1;
         end
         repeat (3) @(posedge clk);
         cmd_fwd <= 1'b0;
         cmd_rev <= 1'b0;
         repeat (2) @(posedge clk);
      end
      // The axis is only treated as done after the settling time has run out
      repeat (SETTLE) @(posedge clk);
   endtask : send
endmodule : cpeg_ctrl_model

// *** tb.sv ***
// Self-checking testbench of the command pulse electronic gear
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic enc_a = 1'b0;
   logic enc_b = 1'b0;
   logic clr = 1'b0;
   logic fit = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, speed_command, rv;
   logic cmd_fwd, cmd_rev, in_pos, err_x, irq;
   logic [1:0] seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int rem = 0;
   int dev = 0;
   int k;
   integer seed = 32'h83ee340b;

   // Short ramp step so a smoothing test fits the run
   cpeg_core #(.RAMP_STEP_CYC(8)) dut (.clk(clk), .rst_b(rst_b), .cmd_fwd_pin(cmd_fwd), .cmd_rev_pin(cmd_rev),
      .enc_a_pin(enc_a), .enc_b_pin(enc_b), .deviation_clear_input(clr), .option_fitted_pin(fit),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .speed_command(speed_command), .in_position_output(in_pos), .error_excess(err_x), .irq(irq));
   cpeg_ctrl_model #(.SETTLE(30)) ctrl (.clk(clk), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev));

   // Free-running clock, 4 ns period
   always #2 clk = ~clk;

   // Hang guard: the whole sequence needs a few hundred clocks
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so they are taken just after that edge
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
      `CHK(nm, e, rv)
   endtask : rd

   // Scaled pulse count with the fractional part carried into the next call
   function automatic int scaled(input int pulses, input int nm, input int dn, inout int r);
      int t;
      t = r + pulses * nm;
      r = t % dn;
      return t / dn;
   endfunction : scaled

   task automatic gear(input int p);
      ctrl.send(p, 1'b0);
      dev += scaled(p, 3, 2, rem);
   endtask : gear

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      rd(cpeg_pkg::OFS_NUM, 32'h1, "num rst");
      rd(cpeg_pkg::OFS_DEN, 32'h1, "den rst");
      rd(cpeg_pkg::OFS_RAMP, 32'h0, "ramp rst");
      rd(cpeg_pkg::OFS_GAIN, 32'h19, "gain rst");
      rd(cpeg_pkg::OFS_INPOS, 32'h64, "inpos rst");
      rd(cpeg_pkg::OFS_STATUS, 32'h1, "status rst");
      rd(4'hc, 32'h0, "unmapped");
      // Numerator write refused while the option is absent
      fit <= 1'b0;
      repeat (6) @(posedge clk);
      wr(cpeg_pkg::OFS_NUM, 32'h5);
      rd(cpeg_pkg::OFS_NUM, 32'h1, "num unfitted");
      fit <= 1'b1;
      repeat (6) @(posedge clk);
      // Range limits of direct and panel entry
      wr(cpeg_pkg::OFS_NUM, 32'hffff);
      rd(cpeg_pkg::OFS_NUM, 32'h7fff, "num clamp");
      wr(cpeg_pkg::OFS_NUM_PANEL, 32'h3039);
      rd(cpeg_pkg::OFS_NUM, 32'h270f, "num panel");
      wr(cpeg_pkg::OFS_RAMP, 32'hea60);
      rd(cpeg_pkg::OFS_RAMP, 32'hc350, "ramp clamp");
      wr(cpeg_pkg::OFS_RAMP, 32'h0);
      // Zero denominator refused and flagged, interrupt masked then raised then cleared
      wr(cpeg_pkg::OFS_DEN, 32'h0);
      rd(cpeg_pkg::OFS_DEN, 32'h1, "den zero");
      wr(cpeg_pkg::OFS_DEN_PANEL, 32'h3039);
      rd(cpeg_pkg::OFS_DEN, 32'h270f, "den panel");
      rd(cpeg_pkg::OFS_STATUS, 32'h9, "status reject");
      `CHK("irq masked", 1'b0, irq)
      wr(cpeg_pkg::OFS_MASK, 32'h8);
      repeat (2) @(posedge clk);
      `CHK("irq set", 1'b1, irq)
      wr(cpeg_pkg::OFS_STATUS, 32'h9);
      repeat (2) @(posedge clk);
      `CHK("irq clear", 1'b0, irq)
      rd(cpeg_pkg::OFS_STATUS, 32'h0, "status w1c");
      // Ratio 3/2 over two random bursts, remainder carried between them
      wr(cpeg_pkg::OFS_NUM, 32'h3);
      wr(cpeg_pkg::OFS_DEN, 32'h2);
      repeat (2) begin
         k = 1 + ($unsigned($random(seed)) % 8);
         gear(k);
         rd(cpeg_pkg::OFS_DEV, 32'(dev), "dev gear");
      end
      rd(cpeg_pkg::OFS_SPEED, 32'(dev * 25), "speed reg");
      `CHK("speed port", 32'(dev * 25), speed_command)
      `CHK("inpos high", 1'b1, in_pos)
      wr(cpeg_pkg::OFS_INPOS, 32'(dev));
      repeat (3) @(posedge clk);
      `CHK("inpos low", 1'b0, in_pos)
      // A zero excess limit trips the excess output; the default limit lets it go
      wr(cpeg_pkg::OFS_EXCESS, 32'h0);
      repeat (3) @(posedge clk);
      `CHK("excess high", 1'b1, err_x)
      wr(cpeg_pkg::OFS_EXCESS, 32'(cpeg_pkg::RST_EXCESS));
      repeat (3) @(posedge clk);
      `CHK("excess low", 1'b0, err_x)
      // Two forward encoder line cycles give eight feedback counts
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {enc_a, enc_b} <= seq[i % 4];
         repeat (2) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      dev -= 8;
      rd(cpeg_pkg::OFS_DEV, 32'(dev), "dev enc");
      // Falling edge of the clear input empties the deviation counter
      wr(cpeg_pkg::OFS_STATUS, 32'hf);
      @(posedge clk);
      clr <= 1'b1;
      repeat (4) @(posedge clk);
      clr <= 1'b0;
      repeat (8) @(posedge clk);
      // Width is the gear droop; if in-position already stood, the clear makes no new rising event
      k = ((dev < 0 ? -dev : dev) < dev + 8) ? 4 : 5;
      dev = 0;
      rd(cpeg_pkg::OFS_DEV, 32'h0, "dev clear");
      rd(cpeg_pkg::OFS_STATUS, 32'(k), "status clear");
      // A long time constant holds pulses back; dropping it releases them all
      wr(cpeg_pkg::OFS_RAMP, 32'h3e8);
      gear(2);
      rd(cpeg_pkg::OFS_DEV, 32'h0, "dev ramp held");
      wr(cpeg_pkg::OFS_RAMP, 32'h0);
      repeat (40) @(posedge clk);
      rd(cpeg_pkg::OFS_DEV, 32'(dev), "dev ramp done");
      // Reverse pulses go through the same gear and count the droop down
      ctrl.send(2, 1'b1);
      dev += scaled(-2, 3, 2, rem);
      rd(cpeg_pkg::OFS_DEV, 32'(dev), "dev reverse");
      final_report();
   end
endmodule : tb
